// File: inc/apm_map.vh
// Purpose: offsets, field positions and timing counts for power management
// Assumes: 100 MHz mclk_i
// Notes: host register offsets are byte offsets from the controller base
`ifndef APM_MAP_VH
`define APM_MAP_VH
`define OFS_STATUS_A 3'h0
`define OFS_STATUS_B 3'h1
`define OFS_DRIVE_OUT 3'h2
`define OFS_RATE_MAIN 3'h4
`define OFS_FIFO_DATA 3'h5
`define OFS_INPUT_RATE 3'h7
`define DOC_MOTOR_LSB 4
`define DOC_MOTOR_MSB 7
`define DOC_RESET_N_BIT 2
`define RSW_RESET_BIT 7
`define RSW_PDOWN_BIT 6
`define MAIN_IDLE_VALUE 8'h80
`define APD_TIME_MS 10
`define CLK_MHZ 100
// Ten milliseconds of mclk_i cycles, sized to the 24-bit timer
`define APD_CYCLES 24'hF4240
`define ECR_MODE_SPP 3'h0
`define ECR_MODE_BIDIR 3'h1
`define ECR_MODE_EPP 3'h4
`endif

// File: hdl/uart_apm.v
// Purpose: auto powerdown control for one serial port
// Assumes: status inputs synchronous to mclk_i
// Notes: ring indicator change detection stays alive in powerdown
`timescale 1ns/1ps
`default_nettype none
module uart_apm (
  input wire mclk_i,
  input wire rst_b_i,
  input wire ce_i,
  input wire auto_en_i,
  input wire direct_pd_i,
  input wire thr_empty_i,
  input wire tsr_empty_i,
  input wire rx_fifo_empty_i,
  input wire rx_idle_i,
  input wire tx_write_i,
  input wire serial_receive_input_i,
  input wire ring_indicator_input_i,
  output reg tx_pd_o,
  output reg rx_pd_o,
  output reg ring_irq_o
);
  reg rxd_q;
  reg ri_q;
  wire rx_edge;
  assign rx_edge = serial_receive_input_i ^ rxd_q;
  always @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      tx_pd_o <= 1'b0;
      rx_pd_o <= 1'b0;
      ring_irq_o <= 1'b0;
      rxd_q <= 1'b1;
      ri_q <= 1'b0;
    end
    else if (ce_i)
    begin
      rxd_q <= serial_receive_input_i;
      ri_q <= ring_indicator_input_i;
      ring_irq_o <= ring_indicator_input_i ^ ri_q;
      if (direct_pd_i)
        tx_pd_o <= 1'b1;
      else if (!auto_en_i || tx_write_i)
        tx_pd_o <= 1'b0;
      else
        tx_pd_o <= thr_empty_i & tsr_empty_i;
      if (direct_pd_i)
        rx_pd_o <= 1'b1;
      else if (!auto_en_i || rx_edge)
        rx_pd_o <= 1'b0;
      else
        rx_pd_o <= rx_fifo_empty_i & rx_idle_i;
    end
  end
endmodule
`default_nettype wire

// File: hdl/pp_apm.v
// Purpose: parallel port EPP and ECP powerdown selection
// Assumes: configuration inputs synchronous to mclk_i
// Notes: re-evaluated every cycle, so any mode change takes effect on the next mclk_i edge
`timescale 1ns/1ps
`default_nettype none
`include "apm_map.vh"
module pp_apm (
  input wire mclk_i,
  input wire rst_b_i,
  input wire ce_i,
  input wire auto_en_i,
  input wire direct_pd_i,
  input wire epp_cfg_en_i,
  input wire ecp_cfg_en_i,
  input wire [2:0] ecr_mode_i,
  output reg epp_pd_o,
  output reg ecp_pd_o
);
  wire ecr_epp;
  wire ecr_std;
  assign ecr_epp = (ecr_mode_i == `ECR_MODE_EPP);
  assign ecr_std = (ecr_mode_i == `ECR_MODE_SPP) ||
    (ecr_mode_i == `ECR_MODE_BIDIR);
  always @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      epp_pd_o <= 1'b0;
      ecp_pd_o <= 1'b0;
    end
    else if (ce_i)
    begin
      // Recomputed each cycle from ecr and configuration
      epp_pd_o <= direct_pd_i | (auto_en_i & (!epp_cfg_en_i |
        (ecp_cfg_en_i & !ecr_epp)));
      ecp_pd_o <= direct_pd_i | (auto_en_i & (!ecp_cfg_en_i |
        ecr_std | ecr_epp));
    end
  end
endmodule
`default_nettype wire

// File: hdl/auto_power_management.v
// Purpose: auto power management for floppy, two serial ports, parallel port
// Assumes: host strobes and address synchronous to mclk_i, one cycle each
// Notes: floppy register storage and core are outside; this block decides
//   power state and gates the drive-facing pins
// Functional notes
// - Auto powerdown exits only on reset or a wake register access; here clearing fdc_auto_en_i also wakes it.
// - Reset exit follows the ordinary reset sequence.
// - Access wake resumes with all prior state intact.
// - Writing a motor enable bit wakes; reading drive control does not.
// - Reading main status wakes the floppy controller.
// - Any read or write of the data port wakes it.
// - After wake the 10 ms timer restarts; all conditions needed again.
// - Non-wake registers stay accessible; written values are kept.
// - Status, input, rate control reads/writes leave it powered down.
// - Software reset via drive control or rate select bit wakes.
// - Motor, select, write data and enable tristate; others stay active.
// - Host bus stays live; irq and dma request held low.
// - Serial transmitter sleeps when holding and shift register empty.
// - Serial receiver sleeps when fifo empty and awaiting start bit.
// - Ring indicator changes still raise interrupts while asleep.
// - Transmit buffer write or receive line change wakes serial port.
// - EPP logic down when disabled or ECP mode not selecting EPP.
// - ECP logic down when disabled or ecr selects SPP/bidir/EPP.
// - Parallel powerdown re-evaluated on every mode change.
// - Serial auto mode per enable bit; direct bits force powerdown.
// - Floppy sleeps when motors off, idle 80H, head unloaded, timer out.
// - Main status or data port access restarts the running timer.
// - Rate select powerdown overrides auto; auto resumes after.
`timescale 1ns/1ps
`default_nettype none
`include "apm_map.vh"
module auto_power_management #(
  parameter [23:0] APD_CYCLES = `APD_CYCLES
) (
  input wire mclk_i,
  input wire rst_b_i,
  input wire ce_i,
  input wire [2:0] addr_i,
  input wire rd_i,
  input wire wr_i,
  input wire [7:0] wdata_i,
  input wire fdc_auto_en_i,
  input wire fdc_direct_pd_i,
  input wire [7:0] main_status_i,
  input wire fdc_int_i,
  input wire head_unload_done_i,
  input wire fdc_irq_i,
  input wire fdc_drq_i,
  input wire [3:0] motor_on_i,
  input wire [3:0] drive_select_i,
  input wire write_bitstream_i,
  input wire write_enable_i,
  input wire step_dir_i,
  input wire step_i,
  input wire head_side_select_i,
  input wire density_select_i,
  input wire [1:0] rate_indicator_i,
  input wire [1:0] uart_auto_en_i,
  input wire [1:0] uart_direct_pd_i,
  input wire [1:0] thr_empty_i,
  input wire [1:0] tsr_empty_i,
  input wire [1:0] rx_fifo_empty_i,
  input wire [1:0] rx_idle_i,
  input wire [1:0] tx_write_i,
  input wire [1:0] serial_receive_input_i,
  input wire [1:0] ring_indicator_input_i,
  input wire pp_auto_en_i,
  input wire pp_direct_pd_i,
  input wire epp_cfg_en_i,
  input wire ecp_cfg_en_i,
  input wire [2:0] ecr_mode_i,
  output reg fdc_pd_o,
  output reg fdc_soft_reset_o,
  output reg floppy_irq_out_o,
  output reg floppy_dma_request_o,
  output reg [3:0] motor_on_outputs_o,
  output reg [3:0] motor_on_outputs_oe_o,
  output reg [3:0] drive_select_outputs_o,
  output reg [3:0] drive_select_outputs_oe_o,
  output reg write_bitstream_out_o,
  output reg write_bitstream_out_oe_o,
  output reg write_enable_o,
  output reg write_enable_oe_o,
  output reg step_dir_o,
  output reg step_o,
  output reg head_side_select_o,
  output reg density_select_out_o,
  output reg [1:0] rate_indicator_outputs_o,
  output reg [1:0] uart_tx_pd_o,
  output reg [1:0] uart_rx_pd_o,
  output reg [1:0] ring_irq_o,
  output reg epp_pd_o,
  output reg ecp_pd_o
);
  localparam [3:0] ST_RUN = 4'h1;
  localparam [3:0] ST_AUTO_PD = 4'h2;
  localparam [3:0] ST_RATE_PD = 4'h4;
  localparam [3:0] ST_DIRECT_PD = 4'h8;

  reg [3:0] state_q;
  reg [3:0] state_d;
  reg [23:0] timer_q;
  reg [23:0] timer_d;
  reg [3:0] motor_q;
  reg [3:0] motor_d;
  reg soft_reset_d;
  wire sel_drive;
  wire sel_rate;
  wire sel_data;
  wire motor_wr_wake;
  wire soft_rst_wake;
  wire rate_pd_req;
  wire timer_touch;
  wire acc_wake;
  wire idle_ok;
  wire pd_now;
  wire [1:0] u_tx;
  wire [1:0] u_rx;
  wire [1:0] u_ri;
  wire epp_pd;
  wire ecp_pd;

  // Decode from address, strobes and write data bits
  assign sel_drive = (addr_i == `OFS_DRIVE_OUT);
  assign sel_rate = (addr_i == `OFS_RATE_MAIN);
  assign sel_data = (addr_i == `OFS_FIFO_DATA);
  assign motor_wr_wake = wr_i && sel_drive &&
    (wdata_i[`DOC_MOTOR_MSB:`DOC_MOTOR_LSB] != 4'h0);
  assign soft_rst_wake = wr_i && ((sel_drive &&
    !wdata_i[`DOC_RESET_N_BIT]) || (sel_rate &&
    wdata_i[`RSW_RESET_BIT]));
  assign rate_pd_req = wr_i && sel_rate && wdata_i[`RSW_PDOWN_BIT] &&
    !wdata_i[`RSW_RESET_BIT];
  assign timer_touch = (rd_i && sel_rate) || ((rd_i || wr_i) && sel_data);
  // Main status read, data port access, motor enable write or software reset
  assign acc_wake = timer_touch || motor_wr_wake || soft_rst_wake;
  assign idle_ok = (motor_q == 4'h0) &&
    (main_status_i == `MAIN_IDLE_VALUE) && !fdc_int_i &&
    head_unload_done_i && (timer_q == 24'h0);
  assign pd_now = (state_d != ST_RUN);

  always @*
  begin
    state_d = state_q;
    timer_d = timer_q;
    motor_d = motor_q;
    soft_reset_d = soft_rst_wake;
    if (wr_i && sel_drive)
      motor_d = wdata_i[`DOC_MOTOR_MSB:`DOC_MOTOR_LSB];
    if (timer_q != 24'h0)
      timer_d = timer_q - 24'h1;
    if (timer_touch)
      timer_d = APD_CYCLES;
    case (state_q)
      ST_RUN:
      begin
        if (fdc_direct_pd_i)
          state_d = ST_DIRECT_PD;
        else if (rate_pd_req)
          state_d = ST_RATE_PD;
        else if (fdc_auto_en_i && idle_ok && !acc_wake)
          state_d = ST_AUTO_PD;
      end
      ST_AUTO_PD:
      begin
        // Other accesses leave power state alone
        if (fdc_direct_pd_i)
          state_d = ST_DIRECT_PD;
        else if (rate_pd_req)
          state_d = ST_RATE_PD;
        else if (acc_wake || !fdc_auto_en_i)
        begin
          state_d = ST_RUN;
          timer_d = APD_CYCLES;
        end
      end
      ST_RATE_PD:
      begin
        if (acc_wake)
        begin
          state_d = ST_RUN;
          timer_d = APD_CYCLES;
        end
      end
      ST_DIRECT_PD:
      begin
        if (!fdc_direct_pd_i)
        begin
          state_d = ST_RUN;
          timer_d = APD_CYCLES;
        end
      end
      default:
        state_d = ST_RUN;
    endcase
    if (!fdc_auto_en_i && state_q == ST_RUN)
      timer_d = APD_CYCLES;
  end

  always @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      // Reset exit is the ordinary reset path
      state_q <= ST_RUN;
      timer_q <= APD_CYCLES;
      motor_q <= 4'h0;
      fdc_pd_o <= 1'b0;
      fdc_soft_reset_o <= 1'b0;
      floppy_irq_out_o <= 1'b0;
      floppy_dma_request_o <= 1'b0;
      motor_on_outputs_o <= 4'h0;
      motor_on_outputs_oe_o <= 4'h0;
      drive_select_outputs_o <= 4'h0;
      drive_select_outputs_oe_o <= 4'h0;
      write_bitstream_out_o <= 1'b0;
      write_bitstream_out_oe_o <= 1'b0;
      write_enable_o <= 1'b0;
      write_enable_oe_o <= 1'b0;
      step_dir_o <= 1'b0;
      step_o <= 1'b0;
      head_side_select_o <= 1'b0;
      density_select_out_o <= 1'b0;
      rate_indicator_outputs_o <= 2'h0;
      uart_tx_pd_o <= 2'h0;
      uart_rx_pd_o <= 2'h0;
      ring_irq_o <= 2'h0;
      epp_pd_o <= 1'b0;
      ecp_pd_o <= 1'b0;
    end
    else if (ce_i)
    begin
      state_q <= state_d;
      timer_q <= timer_d;
      motor_q <= motor_d;
      fdc_pd_o <= pd_now;
      fdc_soft_reset_o <= soft_reset_d;
      floppy_irq_out_o <= pd_now ? 1'b0 : fdc_irq_i;
      floppy_dma_request_o <= pd_now ? 1'b0 : fdc_drq_i;
      motor_on_outputs_o <= motor_on_i;
      motor_on_outputs_oe_o <= {4{!pd_now}};
      drive_select_outputs_o <= drive_select_i;
      drive_select_outputs_oe_o <= {4{!pd_now}};
      write_bitstream_out_o <= write_bitstream_i;
      write_bitstream_out_oe_o <= !pd_now;
      write_enable_o <= write_enable_i;
      write_enable_oe_o <= !pd_now;
      step_dir_o <= step_dir_i;
      step_o <= step_i;
      head_side_select_o <= head_side_select_i;
      density_select_out_o <= density_select_i;
      rate_indicator_outputs_o <= rate_indicator_i;
      uart_tx_pd_o <= u_tx;
      uart_rx_pd_o <= u_rx;
      ring_irq_o <= u_ri;
      epp_pd_o <= epp_pd;
      ecp_pd_o <= ecp_pd;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_uart
      uart_apm u_apm (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .auto_en_i(uart_auto_en_i[g]),
        .direct_pd_i(uart_direct_pd_i[g]),
        .thr_empty_i(thr_empty_i[g]),
        .tsr_empty_i(tsr_empty_i[g]),
        .rx_fifo_empty_i(rx_fifo_empty_i[g]),
        .rx_idle_i(rx_idle_i[g]),
        .tx_write_i(tx_write_i[g]),
        .serial_receive_input_i(serial_receive_input_i[g]),
        .ring_indicator_input_i(ring_indicator_input_i[g]),
        .tx_pd_o(u_tx[g]),
        .rx_pd_o(u_rx[g]),
        .ring_irq_o(u_ri[g])
      );
    end
  endgenerate

  pp_apm u_pp (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .auto_en_i(pp_auto_en_i),
    .direct_pd_i(pp_direct_pd_i),
    .epp_cfg_en_i(epp_cfg_en_i),
    .ecp_cfg_en_i(ecp_cfg_en_i),
    .ecr_mode_i(ecr_mode_i),
    .epp_pd_o(epp_pd),
    .ecp_pd_o(ecp_pd)
  );
endmodule
`default_nettype wire

// File: verification/host_bus_model.sv
// Purpose: host bus master issuing one-cycle register strobes
// Assumes: strobes launched and released on mclk_i rising edges
// Notes: address and data show the inverse pattern while idle
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
  input wire logic mclk_i,
  output logic rd_o,
  output logic wr_o,
  output logic [2:0] addr_o,
  output logic [7:0] wdata_o
);
  initial
  begin
    {rd_o, wr_o, addr_o, wdata_o} = {2'h0, 3'h3, 8'hA5};
  end
  task automatic acc(input logic w, input logic [2:0] a,
    input logic [7:0] d);
    @(posedge mclk_i);
    {rd_o, wr_o, addr_o, wdata_o} <= {!w, w, a, d};
    @(posedge mclk_i);
    {rd_o, wr_o, addr_o, wdata_o} <= {2'h0, ~a, ~d};
  endtask
endmodule
`default_nettype wire

// File: verification/auto_power_management_assertions.sv
// Purpose: port checks for power state decisions
// Assumes: APD_CYCLES handed on from the bound instance
// Notes: serial and ring checks watch port 0
`timescale 1ns/1ps
`default_nettype none
module apm_checker #(
  parameter [23:0] APD_CYCLES = 24'h000014
) (
  input wire mclk_i, rst_b_i, ce_i, rd_i, wr_i, fdc_auto_en_i,
  input wire [2:0] addr_i,
  input wire fdc_direct_pd_i, step_i, step_o, fdc_pd_o,
  input wire floppy_irq_out_o, floppy_dma_request_o, write_enable_oe_o,
  input wire [3:0] motor_on_outputs_oe_o,
  input wire [1:0] uart_auto_en_i, uart_direct_pd_i, thr_empty_i,
  input wire [1:0] tsr_empty_i, tx_write_i, uart_tx_pd_o,
  input wire [1:0] ring_indicator_input_i, ring_irq_o,
  input wire pp_auto_en_i, pp_direct_pd_i, epp_cfg_en_i, ecp_cfg_en_i,
  input wire [2:0] ecr_mode_i,
  input wire epp_pd_o, ecp_pd_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  logic [23:0] awake_q;
  // Cycles spent awake since the last powerdown
  always @(posedge mclk_i)
    if (!rst_b_i || fdc_pd_o)
      awake_q <= 24'h000000;
    else
      awake_q <= awake_q + 24'h000001;
  AST_PD_PINS: assert property (fdc_pd_o |-> !floppy_irq_out_o &&
    !floppy_dma_request_o && motor_on_outputs_oe_o == 4'h0 &&
    !write_enable_oe_o) else $error("drive pins live in powerdown");
  AST_COPY: assert property ($past(rst_b_i) && $past(ce_i) |->
    step_o == $past(step_i)) else $error("step pin not copied");
  AST_WAKE: assert property (ce_i && (rd_i || wr_i) &&
    addr_i == 3'h5 && !fdc_direct_pd_i |=> !fdc_pd_o)
    else $error("data port access did not wake");
  AST_KEEP: assert property (fdc_pd_o && ce_i && rd_i && !wr_i &&
    fdc_auto_en_i && !fdc_direct_pd_i &&
    addr_i inside {3'h0, 3'h1, 3'h2, 3'h7} |=> fdc_pd_o)
    else $error("non-wake read woke floppy");
  AST_REARM: assert property (disable iff (!rst_b_i || fdc_direct_pd_i)
    $rose(fdc_pd_o) && !$past(wr_i) |-> awake_q >= APD_CYCLES - 24'h1)
    else $error("powerdown before timer lapsed");
  AST_TX: assert property (ce_i && uart_auto_en_i[0] && thr_empty_i[0] &&
    tsr_empty_i[0] && !tx_write_i[0] |=> ##1 uart_tx_pd_o[0])
    else $error("idle transmitter awake");
  AST_TX_WAKE: assert property (ce_i && tx_write_i[0] &&
    !uart_direct_pd_i[0] |=> ##1 !uart_tx_pd_o[0])
    else $error("transmit write did not wake");
  AST_RING: assert property ($past(rst_b_i) && ce_i &&
    ring_indicator_input_i[0] != $past(ring_indicator_input_i[0])
    |-> ##[1:2] ring_irq_o[0]) else $error("ring change missed");
  AST_PP: assert property (ce_i && pp_auto_en_i && !pp_direct_pd_i &&
    epp_cfg_en_i && ecp_cfg_en_i && ecr_mode_i == 3'h4 |=> ##1
    !epp_pd_o && ecp_pd_o) else $error("parallel mode select wrong");
endmodule
bind auto_power_management apm_checker #(.APD_CYCLES(APD_CYCLES)) chk (.*);
`default_nettype wire

// File: verification/test_auto_power_management.sv
// Purpose: directed tests of floppy, serial and parallel power states
// Assumes: APD_CYCLES shortened to 20 cycles
// Notes: core pin inputs follow a free-running count
`timescale 1ns/1ps
`default_nettype none
module test_auto_power_management;
  logic mclk_i = 1'b0, rst_b_i = 1'b0, ce_i = 1'b1, fdc_auto_en_i = 1'b1;
  logic fdc_int_i = 1'b0, head_unload_done_i = 1'b1, fdc_direct_pd_i = 1'b0;
  logic [7:0] main_status_i = 8'h80, k = 8'h00;
  wire logic rd_i, wr_i;
  wire logic [2:0] addr_i;
  wire logic [7:0] wdata_i;
  logic [3:0] motor_on_i, drive_select_i;
  logic [1:0] te = 2'h3, uart_auto_en_i = 2'h0, uart_direct_pd_i = 2'h0;
  logic [1:0] tx_write_i = 2'h0, serial_receive_input_i = 2'h3;
  logic [1:0] ring_indicator_input_i = 2'h0, rate_indicator_i;
  logic [1:0] thr_empty_i, tsr_empty_i, rx_fifo_empty_i, rx_idle_i;
  logic fdc_irq_i, fdc_drq_i, write_bitstream_i, write_enable_i, step_dir_i;
  logic step_i, head_side_select_i, density_select_i;
  logic pp_auto_en_i = 1'b1, pp_direct_pd_i = 1'b0;
  logic epp_cfg_en_i = 1'b1, ecp_cfg_en_i = 1'b1;
  logic [2:0] ecr_mode_i = 3'h0;
  logic fdc_pd_o, fdc_soft_reset_o, floppy_irq_out_o, floppy_dma_request_o;
  logic [3:0] motor_on_outputs_o, motor_on_outputs_oe_o;
  logic [3:0] drive_select_outputs_o, drive_select_outputs_oe_o;
  logic write_bitstream_out_o, write_bitstream_out_oe_o, write_enable_o;
  logic write_enable_oe_o, step_dir_o, step_o, head_side_select_o;
  logic density_select_out_o, epp_pd_o, ecp_pd_o;
  logic [1:0] rate_indicator_outputs_o, uart_tx_pd_o, uart_rx_pd_o, ring_irq_o;
  logic [11:0] wk [6] = '{12'hA14, 12'hA00, 12'hC80, 12'h400, 12'h500,
    12'hD5A};
  logic [11:0] nw [7] = '{12'h000, 12'h100, 12'h200, 12'h700, 12'hF02,
    12'hA04, 12'hC01};
  int n_errors = 0, compares = 0, i;
  assign {rate_indicator_i, density_select_i, head_side_select_i, step_i,
    step_dir_i, write_enable_i, write_bitstream_i} = k;
  assign {motor_on_i, drive_select_i, fdc_irq_i, fdc_drq_i} =
    {k[3:0] ^ 4'h5, k[7:4], k[1:0]};
  assign {thr_empty_i, tsr_empty_i, rx_fifo_empty_i, rx_idle_i} = {4{te}};
  auto_power_management #(.APD_CYCLES(24'h000014)) uut (.*);
  host_bus_model hb (.mclk_i, .rd_o(rd_i), .wr_o(wr_i), .addr_o(addr_i),
    .wdata_o(wdata_i));
  always #5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) k <= k + 8'h01;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick;
    @(posedge mclk_i);
    #1;
  endtask
  task automatic sleep;
    for (i = 0; i < 80 && fdc_pd_o !== 1'b1; i++)
      tick();
  endtask
  task automatic acc(input logic [11:0] c);
    hb.acc(c[11], c[10:8], c[7:0]);
    #1;
  endtask
  task automatic set_pp(input logic [6:0] v, input logic [1:0] e);
    @(posedge mclk_i) {pp_auto_en_i, pp_direct_pd_i, epp_cfg_en_i,
      ecp_cfg_en_i, ecr_mode_i} <= v;
    tick();
    tick();
    chk({epp_pd_o, ecp_pd_o}, e);
  endtask
  task automatic results;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    #100us;
    n_errors++;
    results();
  end
  initial
  begin
    repeat (2) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    for (int j = 0; j < 6; j++)
    begin
      sleep();
      chk(fdc_pd_o, 1);
      chk({motor_on_outputs_oe_o, drive_select_outputs_oe_o}, 0);
      acc(wk[j]);
      chk({fdc_pd_o, fdc_soft_reset_o}, j == 1 || j == 2);
      chk(motor_on_outputs_oe_o, 4'hF);
      acc(12'hA04);
    end
    $display("wake accesses done");
    sleep();
    for (int j = 0; j < 7; j++)
    begin
      acc(nw[j]);
      chk(fdc_pd_o, 1);
    end
    $display("non-wake accesses done");
    acc(12'h400);
    acc(12'hC40);
    chk(fdc_pd_o, 1);
    acc(12'hC80);
    chk(fdc_pd_o, 0);
    sleep();
    chk(fdc_pd_o, 1);
    @(posedge mclk_i) fdc_direct_pd_i <= 1'b1;
    acc(12'h400);
    chk({fdc_pd_o, floppy_irq_out_o, floppy_dma_request_o}, 4);
    $display("rate and direct powerdown done");
    @(posedge mclk_i) uart_auto_en_i <= 2'h3;
    tick();
    tick();
    chk({uart_tx_pd_o, uart_rx_pd_o}, 8'h0F);
    @(posedge mclk_i) {serial_receive_input_i, ring_indicator_input_i} <= 4'h1;
    tick();
    tick();
    chk({uart_rx_pd_o, ring_irq_o}, 8'h01);
    @(posedge mclk_i) tx_write_i <= 2'h1;
    @(posedge mclk_i) tx_write_i <= 2'h0;
    tick();
    chk(uart_tx_pd_o, 2'h2);
    @(posedge mclk_i) {uart_auto_en_i, uart_direct_pd_i, te} <= 6'h0B;
    tick();
    tick();
    chk({uart_tx_pd_o, uart_rx_pd_o}, 8'h0A);
    $display("serial ports done");
    for (int j = 0; j < 8; j++)
      set_pp({4'hB, j[2:0]}, {j != 4, j < 2 || j == 4});
    set_pp(7'h44, 2'h3);
    set_pp(7'h1C, 2'h0);
    set_pp(7'h3C, 2'h3);
    $display("parallel port done");
    results();
  end
endmodule
`default_nettype wire
